// >>> hw/irm_core.sv
// Indirect register load/store engine between processor registers and memory
`timescale 1ns/10ps
module irm_core #(
  parameter int ADDR_W = 20
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Operation request from the processor sequencer
  input wire logic op_valid,
  input wire irm_pkg::irm_op_type op_kind,
  input wire logic [3:0] op_reg,
  output logic op_busy,
  output logic op_done,
  // Upper address bits above accumulator one low word
  input wire logic [ADDR_W-17:0] addr_upper,
  // Memory side
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic mem_byte,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // Block context events
  input wire logic block_open,
  input wire logic [15:0] block_open_start,
  input wire logic [15:0] block_open_length,
  input wire logic cycle_call,
  // Processor-side direct write of any existing slot except the next-op slot
  input wire logic cpu_wr,
  input wire logic [3:0] cpu_reg,
  input wire logic [15:0] cpu_data,
  input wire logic [15:0] next_op_addr,
  // Register views
  output logic [15:0] accumulator1_high,
  output logic [15:0] accumulator1_low,
  output logic [15:0] block_start_address,
  output logic [15:0] block_length_words
);
  import irm_pkg::*;

  // ****************************************
  // Parameter check
  // ****************************************
  // Address is the upper nibble plus one 16-bit register word
  if (ADDR_W != ADDR_WIDTH) begin : g_bad_addr_w
    $error("irm_core: address width must be 20");
  end

  // ****************************************
  // Slot decode
  // ****************************************
  function automatic logic slot_exists(input logic [3:0] n);
    slot_exists = (n <= REG_ACC2_LOW) || (n == REG_BLOCK_START) ||
                  (n == REG_BLOCK_LENGTH) || (n >= REG_ACC3_HIGH && n <= REG_ACC4_LOW) ||
                  (n == REG_NEXT_OP);
  endfunction

  localparam int SLOTS_N = 16;

  irm_state_type state;
  irm_state_type next_state;
  irm_op_type cur_kind;
  logic [3:0] cur_reg;
  logic [SLOTS_N-1:0] wr_en;
  logic [SLOTS_N*16-1:0] wr_data;
  logic [SLOTS_N*16-1:0] all_data;

  wire logic start_op = op_valid && (state == IRM_ST_IDLE);
  wire logic op_real = slot_exists(op_reg) && (op_kind != IRM_OP_NONE);
  wire logic take_real = start_op && op_real;
  wire logic take_nop = start_op && !op_real;
  wire logic [15:0] acc1_low_now = all_data[16*REG_ACC1_LOW +: 16];
  wire logic [15:0] acc1_high_now = all_data[16*REG_ACC1_HIGH +: 16];
  wire logic [15:0] block_start_now = all_data[16*REG_BLOCK_START +: 16];
  wire logic [15:0] block_length_now = all_data[16*REG_BLOCK_LENGTH +: 16];
  wire logic [ADDR_W-1:0] op_addr = {addr_upper, acc1_low_now};
  wire logic byte_area = (acc1_low_now >= BYTE_AREA1_LOW && acc1_low_now <= BYTE_AREA1_HIGH) ||
                         (acc1_low_now >= BYTE_AREA2_LOW);
  wire logic ack_seen = (state == IRM_ST_WAIT) && mem_ack;
  wire logic load_ack = ack_seen && (cur_kind == IRM_OP_LOAD);
  wire logic [15:0] load_value = mem_byte ? {BYTE_FILL, mem_rdata[7:0]} : mem_rdata;
  // Store word taken straight from the bank so it is ready with the request
  wire logic [15:0] store_word = all_data[16*op_reg +: 16];
  wire logic [15:0] store_lane = byte_area ? {8'h00, store_word[7:0]} : store_word;

  // ****************************************
  // Slot write selection
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < SLOTS_N; g++) begin : g_wr
      localparam logic [3:0] IDX = 4'(g);
      wire logic hit_load = load_ack && (cur_reg == IDX);
      wire logic hit_cpu = cpu_wr && (cpu_reg == IDX);
      wire logic hit_open = block_open && (IDX == REG_BLOCK_START || IDX == REG_BLOCK_LENGTH);
      wire logic hit_clear = cycle_call && (IDX == REG_BLOCK_START || IDX == REG_BLOCK_LENGTH);
      wire logic hit_pc = (IDX == REG_NEXT_OP);
      wire logic [15:0] open_val = (IDX == REG_BLOCK_START) ? block_open_start :
                                   block_open_length;
      assign wr_en[g] = slot_exists(IDX) &&
                        (hit_load || hit_cpu || hit_open || hit_clear || hit_pc);
      // Priority: next-op address, call clear, block open, indirect load, direct write
      assign wr_data[g*16 +: 16] = hit_pc ? next_op_addr :
                                   hit_clear ? BLOCK_CLEAR :
                                   hit_open ? open_val :
                                   hit_load ? load_value :
                                   cpu_data;
    end
  endgenerate
  // Jumps and inserted levels drive none of the events above, so values hold

  irm_regbank #(
    .WIDTH(16),
    .SLOTS(SLOTS_N)
  ) u_bank (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .rd_sel(op_reg),
    .rd_data(),
    .all_data(all_data)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    unique case (state)
      IRM_ST_IDLE: begin
        if (start_op && op_real) begin
          next_state = IRM_ST_WAIT;
        end else if (start_op) begin
          next_state = IRM_ST_DONE;
        end
      end
      IRM_ST_WAIT: begin
        if (mem_ack) begin
          next_state = IRM_ST_DONE;
        end
      end
      IRM_ST_DONE: begin
        next_state = IRM_ST_IDLE;
      end
      default: begin
        next_state = IRM_ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Sequencer registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= IRM_ST_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Operation latched at take; op_kind and op_reg may move afterwards
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_kind <= IRM_OP_NONE;
      cur_reg <= 4'h0;
    end else if (ce && start_op) begin
      cur_kind <= op_kind;
      cur_reg <= op_reg;
    end
  end

  // ****************************************
  // Memory request
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_req <= 1'b0;
    end else if (ce && take_real) begin
      mem_req <= 1'b1;
    end else if (ce && ack_seen) begin
      mem_req <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_we <= 1'b0;
    end else if (ce && take_real) begin
      mem_we <= (op_kind == IRM_OP_STORE);
    end else if (ce && ack_seen) begin
      mem_we <= 1'b0;
    end
  end

  // ****************************************
  // Memory address and data
  // ****************************************
  // All three freeze at take, so the far side sees them steady until ack
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_addr <= '0;
    end else if (ce && take_real) begin
      mem_addr <= op_addr;
    end
  end

  // Width judged once at take; a load into slot 1 cannot alter it mid-access
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_byte <= 1'b0;
    end else if (ce && take_real) begin
      mem_byte <= byte_area;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_wdata <= 16'h0000;
    end else if (ce && take_real) begin
      mem_wdata <= store_lane;
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      op_done <= 1'b0;
    end else if (ce) begin
      op_done <= (next_state == IRM_ST_DONE);
    end
  end

  // A no-op take goes straight to done, so busy lasts one cycle there
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      op_busy <= 1'b0;
    end else if (ce) begin
      op_busy <= (next_state != IRM_ST_IDLE) || take_nop;
    end
  end

  // ****************************************
  // Register views
  // ****************************************
  // One cycle behind the bank so every output leaves a flop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      accumulator1_high <= REG_RESET;
    end else if (ce) begin
      accumulator1_high <= acc1_high_now;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      accumulator1_low <= REG_RESET;
    end else if (ce) begin
      accumulator1_low <= acc1_low_now;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      block_start_address <= REG_RESET;
    end else if (ce) begin
      block_start_address <= block_start_now;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      block_length_words <= REG_RESET;
    end else if (ce) begin
      block_length_words <= block_length_now;
    end
  end
endmodule

// >>> include/irm_pkg.sv
// Constants and types shared by the indirect register memory access block
package irm_pkg;
  localparam int REG_WIDTH = 16;
  localparam int ADDR_WIDTH = 20;
  localparam int REGNUM_WIDTH = 4;
  // Register slot numbers
  localparam logic [3:0] REG_ACC1_HIGH = 4'h0;
  localparam logic [3:0] REG_ACC1_LOW = 4'h1;
  localparam logic [3:0] REG_ACC2_HIGH = 4'h2;
  localparam logic [3:0] REG_ACC2_LOW = 4'h3;
  localparam logic [3:0] REG_BLOCK_START = 4'h6;
  localparam logic [3:0] REG_BLOCK_LENGTH = 4'h8;
  localparam logic [3:0] REG_ACC3_HIGH = 4'h9;
  localparam logic [3:0] REG_ACC3_LOW = 4'ha;
  localparam logic [3:0] REG_ACC4_HIGH = 4'hb;
  localparam logic [3:0] REG_ACC4_LOW = 4'hc;
  localparam logic [3:0] REG_NEXT_OP = 4'hf;
  // Byte-wide memory windows (16-bit word of the address)
  localparam logic [15:0] BYTE_AREA1_LOW = 16'he400;
  localparam logic [15:0] BYTE_AREA1_HIGH = 16'he7ff;
  localparam logic [15:0] BYTE_AREA2_LOW = 16'hee00;
  localparam logic [7:0] BYTE_FILL = 8'hff;
  // Reset values
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] BLOCK_CLEAR = 16'h0000;
  // Operation codes
  typedef enum logic [1:0] {
    IRM_OP_NONE = 2'b00,
    IRM_OP_LOAD = 2'b01,
    IRM_OP_STORE = 2'b10
  } irm_op_type;
  // Sequencer states, Gray coded along idle -> request -> done
  typedef enum logic [1:0] {
    IRM_ST_IDLE = 2'b00,
    IRM_ST_WAIT = 2'b01,
    IRM_ST_DONE = 2'b11
  } irm_state_type;
endpackage

// >>> hw/irm_regbank.sv
// Sixteen-slot register bank with registered read port
`timescale 1ns/10ps
module irm_regbank #(
  parameter int WIDTH = 16,
  parameter int SLOTS = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [SLOTS-1:0] wr_en,
  input wire logic [SLOTS*WIDTH-1:0] wr_data,
  input wire logic [3:0] rd_sel,
  output logic [WIDTH-1:0] rd_data,
  output logic [SLOTS*WIDTH-1:0] all_data
);
  import irm_pkg::*;

  // Slot select is four bits wide, so the bank shape is fixed
  if (WIDTH != REG_WIDTH || SLOTS != 16) begin : g_bad_shape
    $error("irm_regbank: width must be 16 and slots 16");
  end

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          all_data[g*WIDTH +: WIDTH] <= REG_RESET;
        end else if (ce && wr_en[g]) begin
          all_data[g*WIDTH +: WIDTH] <= wr_data[g*WIDTH +: WIDTH];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data <= REG_RESET;
    end else if (ce) begin
      rd_data <= all_data[rd_sel*WIDTH +: WIDTH];
    end
  end
endmodule

// >>> verification/irm_core_checker.sv
// Concurrent checks on the indirect register access core ports
`timescale 1ns/10ps
module irm_core_checker #(
  parameter int ADDR_W = 20
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire irm_pkg::irm_op_type op_kind,
  input wire logic [ADDR_W-17:0] addr_upper,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_byte,
  input wire logic mem_ack,
  input wire logic op_done,
  input wire logic cycle_call,
  input wire logic [15:0] block_start_address,
  input wire logic [15:0] block_length_words
);
  import irm_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic [15:0] low_word = mem_addr[15:0];
  wire logic in_byte = (low_word >= BYTE_AREA1_LOW && low_word <= BYTE_AREA1_HIGH)
    || low_word >= BYTE_AREA2_LOW;
  chk_req_holds: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before ack");
  chk_done_after_ack: assert property (
    mem_req && mem_ack |=> op_done && !mem_req)
    else $error("no completion after ack");
  chk_done_pulse: assert property (
    op_done |=> !op_done && !mem_req)
    else $error("completion longer than one cycle");
  chk_byte_flag: assert property (
    mem_req |-> mem_byte == in_byte)
    else $error("byte area flag wrong");
  chk_byte_wdata: assert property (
    mem_req && mem_we && mem_byte |-> mem_wdata[15:8] == 8'h00)
    else $error("high byte leaked to byte area");
  chk_kind_dir: assert property (
    $rose(mem_req) |-> mem_we == ($past(op_kind) == IRM_OP_STORE))
    else $error("access direction wrong");
  chk_upper_addr: assert property (
    $rose(mem_req) |-> mem_addr[ADDR_W-1:16] == $past(addr_upper))
    else $error("upper address bits wrong");
  chk_block_clear: assert property (
    cycle_call |-> ##2 block_start_address == BLOCK_CLEAR && block_length_words == BLOCK_CLEAR)
    else $error("block registers not cleared");
endmodule

// >>> verification/irm_mem_model.sv
// Local and global memory answering word and byte accesses
`timescale 1ns/10ps
module irm_mem_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [19:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_byte,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  // Indexed by the low word only; the upper nibble is judged by the checker
  logic [15:0] store [0:65535];
  int acc_cnt;
  int wait_c;
  // Every other access waits three cycles; read data is noise outside ack
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0000;
      wait_c <= 0;
      acc_cnt <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (wait_c < (acc_cnt % 2) * 3) begin
          wait_c <= wait_c + 1;
        end else begin
          mem_ack <= 1'b1;
          wait_c <= 0;
          acc_cnt <= acc_cnt + 1;
          if (mem_we) store[mem_addr[15:0]] <= mem_wdata;
          else if (mem_byte) mem_rdata <= {8'ha5, store[mem_addr[15:0]][7:0]};
          else mem_rdata <= store[mem_addr[15:0]];
        end
      end
    end
  end
endmodule

// >>> verification/indirect_register_memory_access_tb.sv
// Self-checking bench for the indirect register access core
`timescale 1ns/10ps
module indirect_register_memory_access_tb;
  import irm_pkg::*;
  typedef struct {irm_op_type k; logic [3:0] r; logic [15:0] a, d, e;} irm_row_type;
  logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, op_valid = 1'b0, cpu_wr = 1'b0;
  logic block_open = 1'b0, cycle_call = 1'b0;
  irm_op_type op_kind = IRM_OP_NONE;
  logic [3:0] op_reg = 4'h0, cpu_reg = 4'h0, upper = 4'h5;
  logic [3:0] nops [5] = '{4'h4, 4'h5, 4'h7, 4'hd, 4'he};
  logic [15:0] cpu_data = 16'h0000, bo_start = 16'h0000, bo_len = 16'h0000;
  logic [15:0] acc_h, acc_l, bsa, blw, wdat, rdat;
  logic op_busy, op_done, mem_req, mem_we, mem_byte, mem_ack;
  logic [19:0] mem_addr;
  int err_total = 0, comparisons = 0, cycles = 0, n0;
  irm_row_type rows [7] = '{
    '{IRM_OP_STORE, 4'h3, 16'ha000, 16'h1234, 16'h1234},
    '{IRM_OP_STORE, 4'ha, 16'he400, 16'habcd, 16'h00cd},
    '{IRM_OP_STORE, 4'hc, 16'hef00, 16'h5a5a, 16'h005a},
    '{IRM_OP_STORE, 4'hf, 16'ha002, 16'h0000, 16'h0777},
    '{IRM_OP_LOAD, 4'h6, 16'ha000, 16'h0000, 16'h1234},
    '{IRM_OP_LOAD, 4'h0, 16'ha002, 16'h0000, 16'h0777},
    '{IRM_OP_LOAD, 4'h1, 16'he400, 16'h0000, 16'hffcd}};
  always #50 clk_sys = ~clk_sys;
  irm_core dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .op_valid(op_valid),
    .op_kind(op_kind), .op_reg(op_reg), .op_busy(op_busy), .op_done(op_done),
    .addr_upper(upper), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(wdat), .mem_byte(mem_byte), .mem_ack(mem_ack), .mem_rdata(rdat),
    .block_open(block_open), .block_open_start(bo_start), .block_open_length(bo_len),
    .cycle_call(cycle_call), .cpu_wr(cpu_wr), .cpu_reg(cpu_reg), .cpu_data(cpu_data),
    .next_op_addr(16'h0777), .accumulator1_high(acc_h), .accumulator1_low(acc_l),
    .block_start_address(bsa), .block_length_words(blw));
  irm_mem_model mem (.clk_sys(clk_sys), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(wdat), .mem_byte(mem_byte), .mem_ack(mem_ack),
    .mem_rdata(rdat));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] r, input logic [15:0] d);
    cpu_wr <= 1'b1;
    cpu_reg <= r;
    cpu_data <= d;
    @(posedge clk_sys) cpu_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic run_op(input irm_op_type k, input logic [3:0] r);
    op_valid <= 1'b1;
    op_kind <= k;
    op_reg <= r;
    @(posedge clk_sys) op_valid <= 1'b0;
    @(posedge clk_sys);
    check(16'(op_busy), 16'h0001);
    repeat (20) begin
      if (op_done === 1'b1) break;
      @(posedge clk_sys);
    end
    repeat (3) @(posedge clk_sys);
    check(16'(op_busy), 16'h0000);
  endtask
  function automatic logic [15:0] view(input irm_row_type w);
    if (w.k == IRM_OP_STORE) return mem.store[w.a];
    case (w.r)
      4'h0: return acc_h;
      4'h1: return acc_l;
      default: return bsa;
    endcase
  endfunction
  // Hang guard, runs need well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check(bsa, BLOCK_CLEAR);
    bo_start <= 16'h1000;
    bo_len <= 16'h0020;
    block_open <= 1'b1;
    @(posedge clk_sys) block_open <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(bsa, 16'h1000);
    check(blw, 16'h0020);
    $display("block open test done");
    // Addresses stay in local or byte global space, never the page area
    for (int i = 0; i < 7; i++) begin
      if (rows[i].k == IRM_OP_STORE) wr_reg(rows[i].r, rows[i].d);
      wr_reg(4'h1, rows[i].a);
      run_op(rows[i].k, rows[i].r);
      check(view(rows[i]), rows[i].e);
    end
    check(blw, 16'h0020);
    $display("row tests done");
    n0 = mem.acc_cnt;
    foreach (nops[i]) begin
      run_op(IRM_OP_LOAD, nops[i]);
      run_op(IRM_OP_STORE, nops[i]);
    end
    check(16'(mem.acc_cnt), 16'(n0));
    check(acc_l, 16'hffcd);
    $display("no-op test done");
    block_open <= 1'b1;
    cycle_call <= 1'b1;
    @(posedge clk_sys) block_open <= 1'b0;
    cycle_call <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(bsa, BLOCK_CLEAR);
    check(blw, BLOCK_CLEAR);
    $display("cycle call test done");
    // A block open while the enable is low must leave no trace
    ce <= 1'b0;
    bo_start <= 16'h2222;
    block_open <= 1'b1;
    @(posedge clk_sys) block_open <= 1'b0;
    repeat (2) @(posedge clk_sys);
    ce <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check(bsa, BLOCK_CLEAR);
    $display("clock enable test done");
    give_verdict();
  end
endmodule
bind irm_core irm_core_checker #(.ADDR_W(ADDR_W)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .op_kind(op_kind), .addr_upper(addr_upper), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_byte(mem_byte), .mem_ack(mem_ack),
  .op_done(op_done), .cycle_call(cycle_call), .block_start_address(block_start_address),
  .block_length_words(block_length_words));
